/* common/txdma_defines.svh */
// register offsets, field positions and reset values of the transmit dma
// assumes one aligned 32-bit word per register on an AHB-Lite slave
`ifndef TXDMA_DEFINES_SVH
`define TXDMA_DEFINES_SVH

`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_BASE 8'h08
`define OFF_CUR_DESC 8'h0C
`define OFF_END_DESC 8'h10
`define OFF_RX_BUF_LEN 8'h14
`define OFF_REMAIN 8'h18
`define OFF_BUF_ADDR 8'h1C

`define CTRL_MULTI 0
`define CTRL_WORD 1
`define CTRL_ERR_IE 2
`define CTRL_FE_IE 3

`define STAT_IDLE 0
`define STAT_ENABLE 1
`define STAT_OVF 4
`define STAT_FE_ACK 5
`define STAT_FCT_LO 8
`define STAT_FCT_HI 11

`define DESC_WORDS 3'h5
`define DESC_ST_EOM 7
`define DESC_ST_EOT 6

`define RST_CTRL 4'h0
`define RST_BASE 8'h00
`define RST_PTR 16'h0000
`define RST_FCT 4'h0
`define FCT_MAX 4'hF

`endif

/* common/txdma_pkg.sv */
// types shared by the transmit dma channel and its memory read port
// assumes txdma_defines.svh holds all numeric constants
`default_nettype none
package txdma_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DESC,
    ST_WAIT,
    ST_READ,
    ST_SWITCH
  } dma_state_e;

  typedef struct packed {
    logic [23:0] addr;
    logic word;
  } mem_req_s;

  typedef struct packed {
    logic [15:0] chain;
    logic [23:0] buf_ptr;
    logic [15:0] len;
    logic end_of_frame_flag;
    logic eot;
  } desc_s;

  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic valid;
  } ahb_ap_s;
endpackage
`default_nettype wire

/* core/mem_read_port.sv */
// one-outstanding memory read port of the transmit dma
// assumes memory answers each held request with a one-cycle ack
`timescale 1ns/100ps
`default_nettype none
module mem_read_port (
  input wire logic mclk,
  input wire logic reset,
  input wire logic start,
  input wire txdma_pkg::mem_req_s start_cmd,
  output logic mem_req,
  output txdma_pkg::mem_req_s mem_cmd,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  output logic done,
  output logic [15:0] rdata
);
  import txdma_pkg::*;

  // request held until the ack, start ignored while busy
  always_ff @(posedge mclk) begin
    if (reset) begin
      mem_req <= 1'b0;
      mem_cmd <= '0;
    end else if (mem_req && mem_ack) begin
      mem_req <= 1'b0;
    end else if (start && !mem_req) begin
      mem_req <= 1'b1;
      mem_cmd <= start_cmd;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      done <= 1'b0;
      rdata <= 16'h0000;
    end else begin
      done <= mem_req && mem_ack;
      if (mem_req && mem_ack) begin
        // a byte read sits in the low lane
        rdata <= mem_cmd.word ? mem_rdata : {8'h00, mem_rdata[7:0]};
      end
    end
  end
endmodule // mem_read_port
`default_nettype wire

/* core/chained_block_tx_dma.sv */
// transmit chained-block dma channel with AHB-Lite register slave
// assumes one clock, transmitter request on mclk, memory on mem_read_port
//
// How it works
// - 16-bit remaining count drops per read
// - 24-bit buffer address rises per read
// - buffer done when remaining count zero
// - new buffer loads count from descriptor
// - new buffer loads its start address
// - transmitter request reads at buffer address
// - single frame: advance, clear enable, idle
// - control registers kept across stops
// - pointers equal on request in idle: error, no data
// - multi frame stays enabled unless eot, end movable
// - 4-bit counter of unserviced frame ends
// - counter overflow: flag, stop, clear, error
// - channel enable at status bit one
// - descriptor address is base as upper byte over pointer
// - frame end interrupt on frame completion
// - next descriptor pointer loaded on switch
`timescale 1ns/100ps
`include "txdma_defines.svh"
`default_nettype none
module chained_block_tx_dma (
  input wire logic mclk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic tx_req,
  output logic tx_valid,
  output logic [15:0] tx_data,
  output logic tx_word,
  output logic mem_req,
  output txdma_pkg::mem_req_s mem_cmd,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  output logic error_irq,
  output logic frame_end_irq
);
  import txdma_pkg::*;

  dma_state_e state_reg;
  ahb_ap_s ap_reg;
  desc_s desc_reg;
  logic [3:0] ctrl_reg;
  logic channel_enable_reg;
  logic overflow_reg;
  logic [3:0] frame_end_counter_reg;
  logic [7:0] descriptor_base_upper_reg;
  logic [15:0] current_descriptor_pointer_reg;
  logic [15:0] end_descriptor_pointer_reg;
  logic [15:0] rx_buffer_length_reg;
  logic [15:0] remaining_byte_count_reg;
  logic [23:0] current_buffer_address_reg;
  logic [2:0] desc_idx_reg;
  logic rd_start;
  mem_req_s rd_cmd;
  logic rd_done;
  logic [15:0] rd_data;
  logic wr_ctrl, wr_status, wr_base, wr_cur, wr_end, wr_len;
  logic use_word;
  logic [15:0] step;
  logic [15:0] desc_ofs;
  logic frame_end;
  logic ovf_event;
  logic err_event;
  logic hw_disable;
  logic fe_ack;
  logic stop_now;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // zero wait states: read data registered at the address phase edge
  always_ff @(posedge mclk) begin
    if (reset) begin
      ap_reg <= '0;
    end else if (hready) begin
      ap_reg.valid <= hsel && htrans[1];
      ap_reg.write <= hwrite;
      ap_reg.addr <= haddr[7:0];
    end
  end

  function automatic logic [31:0] read_reg(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      `OFF_CTRL: v[3:0] = ctrl_reg;
      `OFF_STATUS: begin
        v[`STAT_IDLE] = (state_reg == ST_IDLE);
        v[`STAT_ENABLE] = channel_enable_reg;
        v[`STAT_OVF] = overflow_reg;
        v[`STAT_FCT_HI:`STAT_FCT_LO] = frame_end_counter_reg;
      end
      `OFF_BASE: v[7:0] = descriptor_base_upper_reg;
      `OFF_CUR_DESC: v[15:0] = current_descriptor_pointer_reg;
      `OFF_END_DESC: v[15:0] = end_descriptor_pointer_reg;
      `OFF_RX_BUF_LEN: v[15:0] = rx_buffer_length_reg;
      `OFF_REMAIN: v[15:0] = remaining_byte_count_reg;
      `OFF_BUF_ADDR: v[23:0] = current_buffer_address_reg;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  always_ff @(posedge mclk) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= read_reg(haddr[7:0]);
    end
  end

  always_comb begin
    wr_ctrl = ap_reg.valid && ap_reg.write && (ap_reg.addr == `OFF_CTRL);
    wr_status = ap_reg.valid && ap_reg.write && (ap_reg.addr == `OFF_STATUS);
    wr_base = ap_reg.valid && ap_reg.write && (ap_reg.addr == `OFF_BASE);
    wr_cur = ap_reg.valid && ap_reg.write && (ap_reg.addr == `OFF_CUR_DESC);
    wr_end = ap_reg.valid && ap_reg.write && (ap_reg.addr == `OFF_END_DESC);
    wr_len = ap_reg.valid && ap_reg.write && (ap_reg.addr == `OFF_RX_BUF_LEN);
    fe_ack = wr_status && hwdata[`STAT_FE_ACK];
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_reg <= `RST_CTRL;
      descriptor_base_upper_reg <= `RST_BASE;
      end_descriptor_pointer_reg <= `RST_PTR;
      rx_buffer_length_reg <= `RST_PTR;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= hwdata[3:0];
      end
      if (wr_base) begin
        descriptor_base_upper_reg <= hwdata[7:0];
      end
      if (wr_end) begin
        end_descriptor_pointer_reg <= hwdata[15:0];
      end
      if (wr_len) begin
        rx_buffer_length_reg <= hwdata[15:0];
      end
    end
  end

  always_comb begin
    // word only from an even address with two bytes left
    use_word = ctrl_reg[`CTRL_WORD] && !current_buffer_address_reg[0]
      && (remaining_byte_count_reg > 16'h0001);
    step = use_word ? 16'h0002 : 16'h0001;
    desc_ofs = {12'h000, desc_idx_reg, 1'b0};
    frame_end = (state_reg == ST_SWITCH) && (desc_reg.end_of_frame_flag || desc_reg.eot);
    // overflow on a frame end at full count
    ovf_event = frame_end && (frame_end_counter_reg == `FCT_MAX);
    stop_now = desc_reg.eot || ovf_event || !ctrl_reg[`CTRL_MULTI];
    err_event = ((state_reg == ST_IDLE) && channel_enable_reg && tx_req
      && (current_descriptor_pointer_reg == end_descriptor_pointer_reg))
      || ovf_event;
    hw_disable = err_event || (frame_end && stop_now);
  end

  // base forms the upper address byte of descriptor reads
  always_comb begin
    rd_start = 1'b0;
    rd_cmd.addr = {descriptor_base_upper_reg,
      current_descriptor_pointer_reg + desc_ofs};
    rd_cmd.word = 1'b1;
    if (state_reg == ST_DESC && !mem_req && !rd_done) begin
      rd_start = 1'b1;
    end else if (state_reg == ST_WAIT && tx_req
        && remaining_byte_count_reg != 16'h0000) begin
      rd_start = 1'b1;
      rd_cmd.addr = current_buffer_address_reg;
      rd_cmd.word = use_word;
    end
  end

  mem_read_port u_port (
    .mclk(mclk),
    .reset(reset),
    .start(rd_start),
    .start_cmd(rd_cmd),
    .mem_req(mem_req),
    .mem_cmd(mem_cmd),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata),
    .done(rd_done),
    .rdata(rd_data)
  );

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (channel_enable_reg && tx_req && !err_event) begin
            state_reg <= ST_DESC;
          end
        end
        ST_DESC: begin
          if (rd_done && desc_idx_reg == `DESC_WORDS - 3'h1) begin
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (remaining_byte_count_reg == 16'h0000) begin
            state_reg <= ST_SWITCH;
          end else if (tx_req) begin
            state_reg <= ST_READ;
          end
        end
        ST_READ: begin
          if (rd_done) begin
            state_reg <= ST_WAIT;
          end
        end
        ST_SWITCH: begin
          if (frame_end && stop_now) begin
            state_reg <= ST_IDLE;
          end else if (frame_end) begin
            state_reg <= ST_IDLE;
          end else begin
            state_reg <= ST_DESC;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      desc_idx_reg <= 3'h0;
      desc_reg <= '0;
    end else if (state_reg != ST_DESC) begin
      desc_idx_reg <= 3'h0;
    end else if (rd_done) begin
      desc_idx_reg <= desc_idx_reg + 3'h1;
      case (desc_idx_reg)
        3'h0: desc_reg.chain <= rd_data;
        3'h1: desc_reg.buf_ptr[15:0] <= rd_data;
        3'h2: desc_reg.buf_ptr[23:16] <= rd_data[7:0];
        3'h3: desc_reg.len <= rd_data;
        3'h4: begin
          desc_reg.end_of_frame_flag <= rd_data[`DESC_ST_EOM];
          desc_reg.eot <= rd_data[`DESC_ST_EOT];
        end
        default: desc_reg <= desc_reg;
      endcase
    end
  end

  // no software path to count or address
  always_ff @(posedge mclk) begin
    if (reset) begin
      remaining_byte_count_reg <= `RST_PTR;
      current_buffer_address_reg <= 24'h00_0000;
    end else if (state_reg == ST_DESC && rd_done
        && desc_idx_reg == `DESC_WORDS - 3'h1) begin
      remaining_byte_count_reg <= desc_reg.len;
      current_buffer_address_reg <= desc_reg.buf_ptr;
    end else if (state_reg == ST_READ && rd_done) begin
      remaining_byte_count_reg <= remaining_byte_count_reg - step;
      current_buffer_address_reg <= current_buffer_address_reg + {8'h00, step};
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      current_descriptor_pointer_reg <= `RST_PTR;
    end else if (state_reg == ST_SWITCH) begin
      current_descriptor_pointer_reg <= desc_reg.chain;
    end else if (wr_cur) begin
      current_descriptor_pointer_reg <= hwdata[15:0];
    end
  end

  // hardware clear beats a same-cycle software write
  always_ff @(posedge mclk) begin
    if (reset) begin
      channel_enable_reg <= 1'b0;
    end else if (hw_disable) begin
      channel_enable_reg <= 1'b0;
    end else if (wr_status) begin
      channel_enable_reg <= hwdata[`STAT_ENABLE];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      frame_end_counter_reg <= `RST_FCT;
    end else if (ovf_event) begin
      frame_end_counter_reg <= `RST_FCT;
    end else if (frame_end && !fe_ack) begin
      frame_end_counter_reg <= frame_end_counter_reg + 4'h1;
    end else if (!frame_end && fe_ack && frame_end_counter_reg != `RST_FCT) begin
      frame_end_counter_reg <= frame_end_counter_reg - 4'h1;
    end
  end

  // set wins over the write-one clear
  always_ff @(posedge mclk) begin
    if (reset) begin
      overflow_reg <= 1'b0;
    end else if (ovf_event) begin
      overflow_reg <= 1'b1;
    end else if (wr_status && hwdata[`STAT_OVF]) begin
      overflow_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      error_irq <= 1'b0;
      frame_end_irq <= 1'b0;
    end else begin
      error_irq <= err_event && ctrl_reg[`CTRL_ERR_IE];
      frame_end_irq <= frame_end && ctrl_reg[`CTRL_FE_IE];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      tx_valid <= 1'b0;
      tx_data <= 16'h0000;
      tx_word <= 1'b0;
    end else begin
      tx_valid <= (state_reg == ST_READ) && rd_done;
      if ((state_reg == ST_READ) && rd_done) begin
        tx_data <= rd_data;
        tx_word <= mem_cmd.word;
      end
    end
  end
endmodule // chained_block_tx_dma
`default_nettype wire

/* tb/tx_dma_assertions.sv */
// port assertions of the transmit dma, bound into its top module
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module tx_dma_checker (
  input wire logic mclk,
  input wire logic reset,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic tx_valid,
  input wire logic [15:0] tx_data,
  input wire logic tx_word,
  input wire logic mem_req,
  input wire txdma_pkg::mem_req_s mem_cmd,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  input wire logic error_irq,
  input wire logic frame_end_irq
);
  import txdma_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or errored");
  // ack edge, then done register, then the valid register: two cycles back
  a_valid_after_ack: assert property (tx_valid |-> $past(mem_ack, 2) && $past(mem_req, 2))
    else $error("data out without a memory answer");
  a_valid_data: assert property (tx_valid |->
    tx_data == (tx_word ? $past(mem_rdata, 2) : ($past(mem_rdata, 2) & 16'h00FF)))
    else $error("data out differs from memory data");
  a_req_held: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_cmd))
    else $error("memory request dropped or changed early");
  a_req_drop: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("memory request kept after answer");
  a_word_even: assert property (mem_req && mem_cmd.word |-> !mem_cmd.addr[0])
    else $error("word read at odd address");
  a_valid_pulse: assert property (tx_valid |=> !tx_valid)
    else $error("data valid longer than one cycle");
  a_err_pulse: assert property (error_irq |=> !error_irq)
    else $error("error pulse too long");
  a_fe_pulse: assert property (frame_end_irq |=> !frame_end_irq)
    else $error("frame end pulse too long");
endmodule // tx_dma_checker
bind chained_block_tx_dma tx_dma_checker u_tx_dma_checker (.mclk, .reset, .hreadyout,
  .hresp, .tx_valid, .tx_data, .tx_word, .mem_req, .mem_cmd, .mem_ack, .mem_rdata,
  .error_irq, .frame_end_irq);
`default_nettype wire

/* tb/tx_mem_model.sv */
// behavioural system memory answering the dma read port
// assumes byte storage filled by the bench through hierarchy
`timescale 1ns/100ps
`default_nettype none
module tx_mem_model (
  input wire logic mclk,
  input wire logic reset,
  input wire logic slow,
  input wire logic mem_req,
  input wire txdma_pkg::mem_req_s mem_cmd,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  import txdma_pkg::*;
  logic [7:0] mem [256];
  logic [1:0] wait_reg;
  logic [7:0] a;
  assign a = mem_cmd.addr[7:0];
  always_ff @(posedge mclk) begin
    if (reset) begin
      mem_ack <= 1'b0;
      wait_reg <= 2'h0;
      mem_rdata <= 16'hA5A5;
    end else begin
      mem_ack <= 1'b0;
      // stale data must not pass for an answer
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
        if (!slow || wait_reg == 2'h3) begin
          mem_ack <= 1'b1;
          mem_rdata <= {mem[a + 8'h01], mem[a]};
          wait_reg <= 2'h0;
        end else begin
          wait_reg <= wait_reg + 2'h1;
        end
      end
    end
  end
endmodule // tx_mem_model
`default_nettype wire

/* tb/chained_block_tx_dma_bench.sv */
// self-checking bench of the transmit dma with its memory model
// assumes a zero-wait bus slave and one memory read at a time
`timescale 1ns/100ps
`include "txdma_defines.svh"
`default_nettype none
module chained_block_tx_dma_bench;
  import txdma_pkg::*;
  logic mclk, reset, hsel, hwrite, hready, hreadyout, hresp, tx_req, slow;
  logic tx_valid, tx_word, mem_req, mem_ack, error_irq, frame_end_irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [15:0] tx_data, mem_rdata;
  mem_req_s mem_cmd;
  logic [16:0] txq [$];
  int mismatches, comparisons, nerr, nfe, nbase;
  assign hready = hreadyout;
  chained_block_tx_dma u_chained_block_tx_dma (.mclk, .reset, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready, .hreadyout, .hrdata, .hresp, .tx_req,
    .tx_valid, .tx_data, .tx_word, .mem_req, .mem_cmd, .mem_ack, .mem_rdata,
    .error_irq, .frame_end_irq);
  tx_mem_model u_tx_mem_model (.mclk, .reset, .slow, .mem_req, .mem_cmd, .mem_ack,
    .mem_rdata);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // mid-cycle sampling keeps the monitor clear of edge races
  always @(negedge mclk) begin
    if (tx_valid === 1'b1) txq.push_back({tx_word, tx_data});
    if (error_irq === 1'b1) nerr++;
    if (frame_end_irq === 1'b1) nfe++;
    // answered reads whose upper address byte is the programmed base
    if (mem_req === 1'b1 && mem_ack === 1'b1 && mem_cmd.addr[23:16] === 8'h5A) nbase++;
  end
  function automatic logic [7:0] fb(logic [7:0] a);
    return a * 8'h03 + 8'h01;
  endfunction
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rc(string n, logic [7:0] a, logic [31:0] e, logic [31:0] m = 32'hFFFFFFFF);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(n, r & m, e);
  endtask
  task automatic rst();
    reset <= 1'b1;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    nerr = 0;
    nfe = 0;
    nbase = 0;
  endtask
  task automatic desc(logic [7:0] p, logic [7:0] ch, logic [7:0] b, logic [15:0] n,
    logic [7:0] st);
    logic [15:0] w [5];
    w = '{{8'h00, ch}, {8'h00, b}, 16'h0000, n, {8'h00, st}};
    for (int i = 0; i < 5; i++) begin
      u_tx_mem_model.mem[p + 8'(2 * i)] = w[i][7:0];
      u_tx_mem_model.mem[p + 8'(2 * i + 1)] = w[i][15:8];
    end
  endtask
  task automatic run(int n);
    int i;
    txq.delete();
    tx_req <= 1'b1;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (i < 3000 && (txq.size() < n || i < 10));
    tx_req <= 1'b0;
    repeat (30) @(posedge mclk);
  endtask
  task automatic start(logic [31:0] c, logic [31:0] cur, logic [31:0] last);
    wr(`OFF_CTRL, c);
    wr(`OFF_CUR_DESC, cur);
    wr(`OFF_END_DESC, last);
    wr(`OFF_STATUS, 32'h2);
  endtask
  task automatic t_regs();
    rc("status", `OFF_STATUS, 32'h1);
    rc("ctrl", `OFF_CTRL, 32'h0);
    wr(`OFF_RX_BUF_LEN, 32'hBEEF);
    rc("buflen", `OFF_RX_BUF_LEN, 32'hBEEF);
    wr(`OFF_REMAIN, 32'h1234);
    wr(`OFF_BUF_ADDR, 32'hABCDEF);
    rc("remain", `OFF_REMAIN, 32'h0);
    rc("bufaddr", `OFF_BUF_ADDR, 32'h0);
    rc("unmapped", 8'h40, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_single();
    logic [7:0] ex [5] = '{8'h80, 8'h81, 8'h82, 8'h90, 8'h91};
    rst();
    desc(8'h10, 8'h20, 8'h80, 16'h0003, 8'h00);
    desc(8'h20, 8'h30, 8'h90, 16'h0002, 8'h80);
    start(32'hC, 32'h10, 32'h40);
    run(5);
    chk("count", txq.size(), 5);
    foreach (ex[i]) chk("byte", txq[i], {9'h000, fb(ex[i])});
    chk("fe", nfe, 1);
    rc("status", `OFF_STATUS, 32'h1, 32'h3);
    rc("cur", `OFF_CUR_DESC, 32'h30);
    rc("remain", `OFF_REMAIN, 32'h0);
    rc("bufaddr", `OFF_BUF_ADDR, 32'h92);
    rc("ctrl", `OFF_CTRL, 32'hC);
    wr(`OFF_END_DESC, 32'h30);
    wr(`OFF_STATUS, 32'h2);
    run(0);
    chk("nodata", txq.size(), 0);
    chk("err", nerr, 1);
    $display("test single done");
  endtask
  task automatic t_multi();
    logic [7:0] ex [3] = '{8'hA0, 8'hA2, 8'hB0};
    rst();
    slow <= 1'b1;
    desc(8'h40, 8'h50, 8'hA0, 16'h0004, 8'h80);
    // odd length: the last single byte must fall back to a byte read
    desc(8'h50, 8'h60, 8'hB0, 16'h0003, 8'h80);
    start(32'hB, 32'h40, 32'h60);
    run(4);
    foreach (ex[i]) chk("word", txq[i], {1'b1, fb(ex[i] + 8'h01), fb(ex[i])});
    chk("tail", txq[3], {9'h000, fb(8'hB2)});
    chk("fe", nfe, 2);
    rc("status", `OFF_STATUS, 32'h203);
    wr(`OFF_STATUS, 32'h22);
    rc("service", `OFF_STATUS, 32'h103);
    rc("cur", `OFF_CUR_DESC, 32'h60);
    slow <= 1'b0;
    $display("test multi done");
  endtask
  task automatic t_ovf();
    rst();
    desc(8'h70, 8'h70, 8'hC0, 16'h0001, 8'h80);
    wr(`OFF_BASE, 32'h5A);
    start(32'h5, 32'h70, 32'h10);
    run(16);
    chk("frames", txq.size(), 16);
    chk("err", nerr, 1);
    chk("base", nbase, 80);
    rc("status", `OFF_STATUS, 32'h11);
    $display("test overflow done");
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    finish_test();
  end
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    tx_req = 1'b0;
    slow = 1'b0;
    reset = 1'b1;
    for (int i = 0; i < 256; i++) u_tx_mem_model.mem[i] = fb(8'(i));
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    t_regs();
    t_single();
    t_multi();
    t_ovf();
    finish_test();
  end
endmodule // chained_block_tx_dma_bench
`default_nettype wire
